// *** design/pals_pkg.sv ***
/*
 Constants for the first port's output latch and analog select block.
 Assumes a single 50 MHz clock and a plain strobe-style register port.
*/
// Behaviour
// - Port data writes land in the output latch.
// - Port data reads return live pin levels.
// - Latch is eight bits, kept over warm resets.
// - Analog select zero gives pin to digital.
// - Analog select one disables digital input buffer.
// - Only bits five and three-zero implemented.
// - Implemented select bits reset to one always.
`default_nettype none
package pals_pkg;
   localparam int PALS_ADDR_W = 4;
   localparam int PALS_DATA_W = 8;
   // Register offsets of this block's own choosing.
   localparam logic [3:0] PALS_OFF_PORT_DATA = 4'h0;
   localparam logic [3:0] PALS_OFF_LATCH = 4'h1;
   localparam logic [3:0] PALS_OFF_ANSEL = 4'h2;
   localparam logic [3:0] PALS_OFF_DIR = 4'h3;
   // Implemented analog select bits and their reset value.
   localparam logic [7:0] PALS_ANSEL_MASK = 8'h2F;
   localparam logic [7:0] PALS_ANSEL_RESET = 8'h2F;
   // Direction register: one means input, reset to all inputs.
   localparam logic [7:0] PALS_DIR_RESET = 8'hFF;
   localparam logic [7:0] PALS_ZERO = 8'h00;
endpackage
`default_nettype wire

// *** design/pals_pin_cell.sv ***
/*
 Per-pin digital and analog steering for one port pin.
 Assumes the pin level input is synchronous to the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module pals_pin_cell (
   input wire logic latch_bit,
   input wire logic dir_input,
   input wire logic analog_sel,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   output logic dig_in,
   output logic analog_en
);
   // The driver is off whenever software asks for input; analog pins rely on that.
   assign pin_out = latch_bit;
   assign pin_oe = ~dir_input;
   // A disabled input buffer reads as zero so a floating level never leaks in.
   assign dig_in = pin_in & ~analog_sel;
   assign analog_en = analog_sel;
endmodule // pals_pin_cell
`default_nettype wire

// *** design/pals_port_a.sv ***
/*
 First general purpose port: output latch, analog select and direction,
 reached over a strobe register port with read data one cycle later.
 Assumes pin inputs are synchronous to clk and an external pad resolves levels.
 Power-on reset por_n also does everything rst_n does; rst_n alone keeps the
 output latch. The latch starts at zero here, a value real pads leave undefined,
 so software must never rely on it.
*/
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module pals_port_a
   import pals_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic por_n,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   output logic [7:0] analog_en,
   output logic [7:0] dig_in
);
   // State registers and the next read word.
   logic [7:0] latch_q;
   logic [7:0] ansel_q;
   logic [7:0] dir_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic wr_port;
   logic wr_latch;
   logic wr_ansel;
   logic wr_dir;

   // Address decode for writes; port data and latch share one storage.
   assign wr_port = wr && (addr == PALS_OFF_PORT_DATA);
   assign wr_latch = wr && (addr == PALS_OFF_LATCH);
   assign wr_ansel = wr && (addr == PALS_OFF_ANSEL);
   assign wr_dir = wr && (addr == PALS_OFF_DIR);

   // Output latch: cleared only by power-on reset por_n, left alone by rst_n.
   // Power-on content is really unknown; zero is the safe synthesizable stand-in.
   always_ff @(posedge clk or negedge por_n) begin
      if (!por_n) begin
         latch_q <= PALS_ZERO;
      end else if (wr_port || wr_latch) begin
         latch_q <= wdata;
      end
   end

   // Analog select and direction return to their defaults on every reset.
   // Unimplemented select bits are masked on write so they can only read zero.
   always_ff @(posedge clk or negedge rst_n or negedge por_n) begin
      if (!rst_n || !por_n) begin
         ansel_q <= PALS_ANSEL_RESET;
         dir_q <= PALS_DIR_RESET;
      end else begin
         if (wr_ansel) begin
            ansel_q <= wdata & PALS_ANSEL_MASK;
         end
         if (wr_dir) begin
            dir_q <= wdata;
         end
      end
   end

   // Per-pin steering cells.
   genvar i;
   generate
      for (i = 0; i < PALS_DATA_W; i++) begin : g_pin
         pals_pin_cell u_cell (
            .latch_bit(latch_q[i]),
            .dir_input(dir_q[i]),
            .analog_sel(ansel_q[i]),
            .pin_in(pin_in[i]),
            .pin_out(pin_out[i]),
            .pin_oe(pin_oe[i]),
            .dig_in(dig_in[i]),
            .analog_en(analog_en[i])
         );
      end
   endgenerate

   // Read mux: port data shows pins, not the latch; unmapped reads give zero.
   assign rdata_d = !rd ? PALS_ZERO :
                    (addr == PALS_OFF_PORT_DATA) ? dig_in :
                    (addr == PALS_OFF_LATCH) ? latch_q :
                    (addr == PALS_OFF_ANSEL) ? ansel_q :
                    (addr == PALS_OFF_DIR) ? dir_q : PALS_ZERO;

   // Read data stands only in the cycle after the strobe.
   // A zero idle value lets several slaves share one read bus by a plain OR.
   always_ff @(posedge clk or negedge rst_n or negedge por_n) begin
      if (!rst_n || !por_n) begin
         rdata_q <= PALS_ZERO;
      end else begin
         rdata_q <= rdata_d;
      end
   end
   assign rdata = rdata_q;

   // Checks below watch only state and outputs that this block drives.
   // A port data write must be the next latch value.
   property p_write_latch;
      @(posedge clk) disable iff (!rst_n || !por_n)
      (wr && (addr == PALS_OFF_PORT_DATA)) |=> (latch_q == $past(wdata));
   endproperty
   a_write_latch: assert property (p_write_latch) else $error("latch missed write");

   // A port data read shows the pins as they stood at the strobe.
   property p_read_pins;
      @(posedge clk) disable iff (!rst_n || !por_n)
      (rd && (addr == PALS_OFF_PORT_DATA)) |=> (rdata == $past(pin_in & ~ansel_q));
   endproperty
   a_read_pins: assert property (p_read_pins) else $error("port read not pins");

   // Without a write the latch holds, across warm resets too.
   property p_latch_hold;
      @(posedge clk) disable iff (!por_n)
      !(wr_port || wr_latch) |=> $stable(latch_q);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch changed");

   // With every select bit clear each pin reads straight through.
   property p_digital;
      @(posedge clk) disable iff (!rst_n || !por_n)
      (ansel_q == PALS_ZERO) |-> (dig_in == pin_in) && (analog_en == PALS_ZERO);
   endproperty
   a_digital: assert property (p_digital) else $error("digital pin lost");

   // An analog pin never reaches the digital side.
   property p_analog;
      @(posedge clk) disable iff (!rst_n || !por_n)
      ((analog_en & dig_in) == PALS_ZERO) && (analog_en == ansel_q);
   endproperty
   a_analog: assert property (p_analog) else $error("analog buffer on");

   // Select bits that do not exist always read as zero.
   property p_unimpl;
      @(posedge clk) disable iff (!rst_n || !por_n)
      (rd && (addr == PALS_OFF_ANSEL)) |=> ((rdata & ~PALS_ANSEL_MASK) == PALS_ZERO);
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

   // Leaving a warm reset, every implemented select bit is back at analog.
   property p_ansel_reset;
      @(posedge clk) disable iff (!por_n)
      $rose(rst_n) |-> (ansel_q == PALS_ANSEL_RESET);
   endproperty
   a_ansel_reset: assert property (p_ansel_reset) else $error("select reset wrong");

   // Port data reads of analog pins give zero, not the pin level.
   property p_analog_read_zero;
      @(posedge clk) disable iff (!rst_n || !por_n)
      (rd && (addr == PALS_OFF_PORT_DATA)) |=> ((rdata & $past(ansel_q)) == PALS_ZERO);
   endproperty
   a_analog_read_zero: assert property (p_analog_read_zero)
      else $error("analog pin read");

   // A write to the latch offset lands like a port data write.
   property p_latch_off_write;
      @(posedge clk) disable iff (!rst_n || !por_n)
      wr_latch |=> (latch_q == $past(wdata));
   endproperty
   a_latch_off_write: assert property (p_latch_off_write)
      else $error("latch offset write lost");

   // The latch offset reads back the latch, not the pins.
   property p_latch_read;
      @(posedge clk) disable iff (!rst_n || !por_n)
      (rd && (addr == PALS_OFF_LATCH)) |=> (rdata == $past(latch_q));
   endproperty
   a_latch_read: assert property (p_latch_read)
      else $error("latch read wrong");

   // Leaving power-on reset the latch holds its chosen start value.
   property p_latch_por;
      @(posedge clk)
      $rose(por_n) |-> (latch_q == PALS_ZERO);
   endproperty
   a_latch_por: assert property (p_latch_por)
      else $error("latch start value wrong");

   // Pads always see the latch, and drive only where direction is output.
   property p_pin_drive;
      @(posedge clk) disable iff (!por_n)
      (pin_out == latch_q) && (pin_oe == ~dir_q);
   endproperty
   a_pin_drive: assert property (p_pin_drive)
      else $error("pin drive wrong");

   // Each digital pin passes its level, whatever the other pins select.
   property p_digital_bits;
      @(posedge clk) disable iff (!rst_n || !por_n)
      ((dig_in ^ pin_in) & ~ansel_q) == PALS_ZERO;
   endproperty
   a_digital_bits: assert property (p_digital_bits)
      else $error("digital pin blocked");

   // Select writes keep only the implemented bits.
   property p_ansel_write;
      @(posedge clk) disable iff (!rst_n || !por_n)
      wr_ansel |=> (ansel_q == ($past(wdata) & PALS_ANSEL_MASK));
   endproperty
   a_ansel_write: assert property (p_ansel_write)
      else $error("select write wrong");

   // Direction writes land whole.
   property p_dir_write;
      @(posedge clk) disable iff (!rst_n || !por_n)
      wr_dir |=> (dir_q == $past(wdata));
   endproperty
   a_dir_write: assert property (p_dir_write)
      else $error("direction write wrong");

   // While a warm reset stands, select and direction sit at their defaults.
   property p_reset_hold;
      @(posedge clk) disable iff (!por_n)
      !rst_n |-> (ansel_q == PALS_ANSEL_RESET) && (dir_q == PALS_DIR_RESET);
   endproperty
   a_reset_hold: assert property (p_reset_hold)
      else $error("reset defaults wrong");

   // Read data is zero in any cycle that does not answer a strobe.
   property p_idle_read;
      @(posedge clk) disable iff (!rst_n || !por_n)
      !rd |=> (rdata == PALS_ZERO);
   endproperty
   a_idle_read: assert property (p_idle_read)
      else $error("idle read data not zero");

   // Reads of unmapped offsets give zero.
   property p_unmapped_read;
      @(posedge clk) disable iff (!rst_n || !por_n)
      (rd && (addr > PALS_OFF_DIR)) |=> (rdata == PALS_ZERO);
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("unmapped read not zero");
endmodule // pals_port_a
`default_nettype wire

// *** tb/pals_ext_model.sv ***
/*
 External circuit on the first port's pins.
 Assumes pin_oe high means the port drives the pin.
*/
`timescale 1ns/1ns
`default_nettype none
module pals_ext_model (
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] ext_level,
   output logic [7:0] pin_in
);
   // A driven pin shows the latch; an input pin shows the outside level.
   assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule // pals_ext_model
`default_nettype wire

// *** tb/tb.sv ***
/*
 Testbench for the first port: register table rows, then warm reset.
 Assumes the external model closes the pin loop.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
   import pals_pkg::*;
   logic clk, rst_n, por_n, wr, rd;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, pin_in, pin_out, pin_oe, analog_en, dig_in;
   logic [7:0] ext = 8'h5A;
   int n_mismatch = 0;
   int tests_run = 0;
   // Rows: write address, write data, read address, expected read.
   logic [23:0] rows [8] = '{24'h0A51A5, 24'h2FF22F, 24'h200200, 24'h3FF05A,
      24'h3000A5, 24'h3FF05A, 24'h22F050, 24'hF12F00};
   pals_port_a u_dut (.clk(clk), .rst_n(rst_n), .por_n(por_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .analog_en(analog_en), .dig_in(dig_in));
   pals_ext_model u_ext (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
      .pin_in(pin_in));
   initial begin
      clk = 0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so look there.
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1; addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task automatic end_of_test;
      $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Power-on reset, table rows, then a warm reset that must keep the latch.
   initial begin
      rst_n = 0; por_n = 0; wr = 0; rd = 0; addr = 4'h0; wdata = 8'h00;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1; por_n <= 1'b1;
      rd_chk(PALS_OFF_ANSEL, 8'h2F);
      rd_chk(PALS_OFF_DIR, 8'hFF);
      // Direction rows switch pins to output and back to input before analog reads.
      foreach (rows[i]) begin
         wr_reg(rows[i][23:20], rows[i][19:12]);
         rd_chk(rows[i][11:8], rows[i][7:0]);
      end
      chk(dig_in, 8'h50);
      chk(analog_en, 8'h2F);
      wr_reg(PALS_OFF_ANSEL, 8'h00);
      wr_reg(PALS_OFF_DIR, 8'h00);
      @(posedge clk) rst_n <= 1'b0;
      @(posedge clk) rst_n <= 1'b1;
      rd_chk(PALS_OFF_LATCH, 8'hA5);
      chk(analog_en, 8'h2F);
      chk(pin_oe, 8'h00);
      chk(pin_out, 8'hA5);
      wr_reg(PALS_OFF_LATCH, 8'h3C);
      rd_chk(PALS_OFF_LATCH, 8'h3C);
      chk(pin_out, 8'h3C);
      // A power-on pulse clears the latch, which a warm reset never does.
      @(posedge clk) por_n <= 1'b0;
      @(posedge clk) por_n <= 1'b1;
      rd_chk(PALS_OFF_LATCH, 8'h00);
      rd_chk(PALS_OFF_ANSEL, 8'h2F);
      end_of_test();
   end
endmodule // tb
`default_nettype wire
